// ==== src/dpct_pkg.sv ====
package dpct_pkg;

  typedef enum logic [1:0] {
    DPCT_X4,
    DPCT_X8,
    DPCT_X16
  } dpct_width_t;

  localparam int DPCT_CLK_PERIOD_PS = 25000;
  localparam int DPCT_ENTRY_DELAY_NS = 200;
  localparam int DPCT_SETTLE_NS = 200;
  // Least time: round up
  localparam int DPCT_ENTRY_CYCLES =
    (DPCT_ENTRY_DELAY_NS * 1000 + DPCT_CLK_PERIOD_PS - 1) / DPCT_CLK_PERIOD_PS;
  // Longest time: round down, at least one
  localparam int DPCT_SETTLE_RAW = (DPCT_SETTLE_NS * 1000) / DPCT_CLK_PERIOD_PS;
  localparam int DPCT_SETTLE_CYCLES = (DPCT_SETTLE_RAW < 1) ? 1 : DPCT_SETTLE_RAW;
  localparam int DPCT_NUM_TERMS = 10;
  localparam int DPCT_DQ_W = 16;

  // Test input pins, active-low pins keep their _n
  typedef struct packed {
    logic [1:0] ba;
    logic [1:0] bg;
    logic [13:0] a;
    logic we_n_a14;
    logic cas_n_a15;
    logic ras_n_a16;
    logic reset_n;
    logic cke;
    logic act_n;
    logic odt;
    logic ck_t;
    logic ck_c;
    logic ldm_n;
    logic udm_n;
    logic par;
    logic alert_n;
  } dpct_test_in_t;

  typedef struct packed {
    logic [DPCT_DQ_W-1:0] dq;
    logic dqsl_t;
    logic dqsl_c;
    logic dqsu_t;
    logic dqsu_c;
  } dpct_test_out_t;

endpackage

// ==== src/dpct_terms.sv ====
`timescale 1ns/1ps
module dpct_terms
  import dpct_pkg::*;
#(
  parameter dpct_width_t WIDTH = DPCT_X16
) (
  input wire dpct_test_in_t pins,
  input wire logic test_enable_pin,
  output logic [DPCT_NUM_TERMS-1:0] xor_term
);

  logic is_x16;
  logic is_x8;
  assign is_x16 = (WIDTH == DPCT_X16);
  assign is_x8 = (WIDTH == DPCT_X8);

  always_comb begin
    xor_term[0] = pins.a[1] ^ pins.a[6] ^ pins.par;
    xor_term[1] = pins.a[8] ^ pins.alert_n ^ pins.a[9];
    xor_term[2] = pins.a[2] ^ pins.a[5] ^ pins.cas_n_a15;
    xor_term[3] = pins.a[0] ^ pins.a[7] ^ pins.a[11];
    xor_term[4] = pins.ck_c ^ pins.odt ^ pins.cas_n_a15;
    xor_term[5] = pins.cke ^ pins.ras_n_a16 ^ pins.ras_n_a16 ^ pins.a[10];
    xor_term[6] = pins.act_n ^ pins.a[4] ^ pins.ba[1];
    // Width picks the mask pins that exist on the package
    xor_term[7] = (is_x16 ? pins.udm_n : pins.bg[1])
                ^ ((is_x8 | is_x16) & pins.ldm_n) ^ pins.ck_t;
    xor_term[8] = pins.we_n_a14 ^ pins.a[12] ^ pins.ba[0];
    xor_term[9] = pins.bg[0] ^ pins.a[3] ^ (pins.reset_n & test_enable_pin);
  end

endmodule

// ==== src/dpct_top.sv ====
`timescale 1ns/1ps
// Function
// - Test-enable high bypasses memory function; pins become test inputs and outputs.
// - Check mode begins after entry delay; tester waits 200 ns.
// - Clock pins not used as clock in check mode, only as term inputs; outputs purely combinational.
// - Test outputs driven only while chip select low, else released.
// - Outputs settle within 200 ns of new inputs.
// - No array refresh, external or internal, during check mode.
// - All on-die termination off while in check mode.
// - Test-enable accepted from any state, including low power and self refresh.
// - Terms 0 to 3 are fixed three-input XORs.
// - Terms 4 to 6 are fixed XORs of clock, command and address pins.
// - Term 7 width-dependent mask XOR; terms 8 and 9 fixed XORs.
// - x16 even DQ0..DQ10 carry terms 0..5; odd neighbours inverted.
// - x16 DQ12..DQ15 and both strobe pairs from terms 6..9.
// - x4 DQ pins XOR term pairs; strobe pair terms 8, 9.
// - Check mode present on x16; optional on x8/x4 at 8Gb or more.
module dpct_top
  import dpct_pkg::*;
#(
  parameter dpct_width_t WIDTH = DPCT_X16,
  parameter bit CHECK_PRESENT = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic test_enable_pin,
  input wire logic cs_n,
  input wire dpct_test_in_t test_in,
  input wire logic refresh_req,
  input wire logic odt_enable_req,
  output dpct_test_out_t test_out,
  output dpct_test_out_t test_out_oe,
  output logic pin_continuity_check_mode,
  output logic memory_bypass,
  output logic refresh_allow,
  output logic odt_active,
  output logic reinit_required
);

  localparam int CNT_W = $clog2(DPCT_ENTRY_CYCLES + 1);
  localparam logic [CNT_W-1:0] ENTRY_LAST = CNT_W'(DPCT_ENTRY_CYCLES - 1);

  typedef enum logic [1:0] {
    DPCT_NORMAL,
    DPCT_ENTERING,
    DPCT_CHECK
  } dpct_state_t;

  dpct_state_t state;
  logic [CNT_W-1:0] entry_cnt;
  logic [DPCT_NUM_TERMS-1:0] xor_term;
  logic ten_on;
  dpct_test_out_t next_out;

  // Absent on optional widths: pin still feeds term 9 but never starts check mode
  assign ten_on = test_enable_pin & (CHECK_PRESENT | (WIDTH == DPCT_X16));

  ////////////////////////////////////////////////////////////////////////////
  // Entry sequencing and the reinit flag, the only parts needing the clock

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= DPCT_NORMAL;
    end else if (!ten_on) begin
      state <= DPCT_NORMAL;
    end else begin
      case (state)
        DPCT_NORMAL: state <= DPCT_ENTERING;
        DPCT_ENTERING: begin
          if (entry_cnt == ENTRY_LAST) begin
            state <= DPCT_CHECK;
          end
        end
        DPCT_CHECK: state <= DPCT_CHECK;
        default: state <= DPCT_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      entry_cnt <= '0;
    end else if (state == DPCT_ENTERING) begin
      entry_cnt <= entry_cnt + CNT_W'(1);
    end else begin
      entry_cnt <= '0;
    end
  end

  // Sticky until a reset: array contents no longer trusted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reinit_required <= 1'b0;
    end else if (ten_on) begin
      reinit_required <= 1'b1;
    end
  end

  assign pin_continuity_check_mode = (state == DPCT_CHECK);
  // Bypass and refresh/ODT blocking act as soon as the pin rises
  assign memory_bypass = ten_on;
  assign refresh_allow = refresh_req & ~ten_on;
  assign odt_active = odt_enable_req & ~ten_on;

  ////////////////////////////////////////////////////////////////////////////
  // Clockless XOR network

  dpct_terms #(
    .WIDTH(WIDTH)
  ) u_terms (
    .pins(test_in),
    .test_enable_pin(test_enable_pin),
    .xor_term(xor_term)
  );

  always_comb begin
    next_out = '0;
    case (WIDTH)
      DPCT_X16: begin
        for (int i = 0; i < 6; i++) begin
          next_out.dq[2*i] = xor_term[i];
          next_out.dq[2*i+1] = ~xor_term[i];
        end
        next_out.dq[12] = xor_term[6];
        next_out.dq[13] = xor_term[7];
        next_out.dq[14] = xor_term[8];
        next_out.dq[15] = ~xor_term[8];
        next_out.dqsl_t = xor_term[9];
        next_out.dqsl_c = ~xor_term[6];
        next_out.dqsu_t = ~xor_term[9];
        next_out.dqsu_c = ~xor_term[7];
      end
      DPCT_X8: begin
        next_out.dq[7:0] = xor_term[7:0];
        next_out.dqsl_c = xor_term[8];
        next_out.dqsl_t = xor_term[9];
      end
      default: begin
        for (int i = 0; i < 4; i++) begin
          next_out.dq[i] = xor_term[2*i] ^ xor_term[2*i+1];
        end
        next_out.dqsl_c = xor_term[8];
        next_out.dqsl_t = xor_term[9];
      end
    endcase
  end

  // No flops here: clock pins are ordinary term inputs, so the result
  // follows inputs at once, well inside the settle window
  assign test_out = next_out;

  // Drive only the pins that exist, only in check mode with chip select low
  always_comb begin
    test_out_oe = '0;
    if (pin_continuity_check_mode && !cs_n) begin
      case (WIDTH)
        DPCT_X16: test_out_oe = '1;
        DPCT_X8: begin
          test_out_oe.dq[7:0] = '1;
          test_out_oe.dqsl_t = 1'b1;
          test_out_oe.dqsl_c = 1'b1;
        end
        default: begin
          test_out_oe.dq[3:0] = '1;
          test_out_oe.dqsl_t = 1'b1;
          test_out_oe.dqsl_c = 1'b1;
        end
      endcase
    end
  end

endmodule

// ==== test/dpct_tester.sv ====
`timescale 1ns/1ps
module dpct_tester
  import dpct_pkg::*;
(
  input wire dpct_test_in_t pat,
  input wire logic en,
  input wire logic sel,
  input wire dpct_test_out_t test_out,
  input wire dpct_test_out_t test_out_oe,
  output dpct_test_in_t test_in,
  output logic test_enable_pin,
  output logic cs_n,
  output dpct_test_out_t bus
);
  always_comb begin
    test_in = pat;
    test_in.reset_n = 1'h1;
  end
  assign test_enable_pin = en;
  assign cs_n = !sel;
  // No pull on the lines: a released pin reads inverted
  assign bus = ~(test_out ^ test_out_oe);
endmodule

// ==== test/dpct_top_sva.sv ====
`timescale 1ns/1ps
module dpct_top_sva
  import dpct_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic test_enable_pin,
  input wire logic cs_n,
  input wire logic refresh_req,
  input wire logic odt_enable_req,
  input wire dpct_test_out_t test_out_oe,
  input wire logic pin_continuity_check_mode,
  input wire logic memory_bypass,
  input wire logic refresh_allow,
  input wire logic odt_active,
  input wire logic reinit_required
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  property p_oe; test_out_oe == ((pin_continuity_check_mode && !cs_n) ? '1 : '0); endproperty
  a_oe: assert property (p_oe) else $error("oe wrong");
  property p_early; $rose(test_enable_pin) ##0 test_enable_pin[*8] |-> !pin_continuity_check_mode; endproperty
  a_early: assert property (p_early) else $error("mode early");
  property p_enter; $rose(test_enable_pin) ##0 test_enable_pin[*8] ##1 test_enable_pin |=> pin_continuity_check_mode; endproperty
  a_enter: assert property (p_enter) else $error("mode late");
  property p_exit; !test_enable_pin |=> !pin_continuity_check_mode; endproperty
  a_exit: assert property (p_exit) else $error("mode stuck");
  property p_bypass; memory_bypass == test_enable_pin; endproperty
  a_bypass: assert property (p_bypass) else $error("bypass wrong");
  property p_refresh; refresh_allow == (refresh_req && !test_enable_pin); endproperty
  a_refresh: assert property (p_refresh) else $error("refresh wrong");
  property p_odt; odt_active == (odt_enable_req && !test_enable_pin); endproperty
  a_odt: assert property (p_odt) else $error("odt wrong");
  property p_reinit; test_enable_pin || reinit_required |=> reinit_required; endproperty
  a_reinit: assert property (p_reinit) else $error("reinit wrong");
endmodule
bind dpct_top dpct_top_sva u_sva (.*);

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import dpct_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic en = 1'h0;
  logic sel = 1'h0;
  logic refresh_req = 1'h1;
  logic odt_enable_req = 1'h1;
  dpct_test_in_t pat = '0;
  dpct_test_in_t test_in;
  logic test_enable_pin, cs_n, pin_continuity_check_mode, memory_bypass;
  logic refresh_allow, odt_active, reinit_required;
  dpct_test_out_t test_out, test_out_oe, bus;
  int failures = 0;
  int n_compared = 0;
  always #12.5 clk = ~clk;
  dpct_top uut (.*);
  dpct_tester partner (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(string name, logic [39:0] seen, logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic dpct_test_out_t model(dpct_test_in_t p, logic t);
    logic [9:0] m;
    dpct_test_out_t o;
    m[0] = p.a[1] ^ p.a[6] ^ p.par;
    m[1] = p.a[8] ^ p.alert_n ^ p.a[9];
    m[2] = p.a[2] ^ p.a[5] ^ p.cas_n_a15;
    m[3] = p.a[0] ^ p.a[7] ^ p.a[11];
    m[4] = p.ck_c ^ p.odt ^ p.cas_n_a15;
    m[5] = p.cke ^ p.ras_n_a16 ^ p.ras_n_a16 ^ p.a[10];
    m[6] = p.act_n ^ p.a[4] ^ p.ba[1];
    m[7] = p.udm_n ^ p.ldm_n ^ p.ck_t;
    m[8] = p.we_n_a14 ^ p.a[12] ^ p.ba[0];
    m[9] = p.bg[0] ^ p.a[3] ^ (p.reset_n & t);
    o.dq = {~m[8], m[8:6], ~m[5], m[5], ~m[4], m[4], ~m[3], m[3], ~m[2], m[2],
            ~m[1], m[1], ~m[0], m[0]};
    o.dqsl_t = m[9];
    o.dqsl_c = ~m[6];
    o.dqsu_t = ~m[9];
    o.dqsu_c = ~m[7];
    return o;
  endfunction
  task automatic t_entry();
    en = 1'h1;
    #1;
    chk("gating", {memory_bypass, refresh_allow, odt_active}, 40'h4);
    step(8);
    chk("early", pin_continuity_check_mode, 40'h0);
    step(1);
    chk("entered", {pin_continuity_check_mode, reinit_required}, 40'h3);
  endtask
  task automatic t_abort();
    en = 1'h1;
    step(4);
    en = 1'h0;
    step(1);
    chk("aborted", pin_continuity_check_mode, 40'h0);
    t_entry();
  endtask
  task automatic t_patterns();
    sel = 1'h1;
    for (int i = 0; i < 31; i++) begin
      pat = dpct_test_in_t'(31'h0000_0001 << i);
      step(1);
      chk("pins", 40'(bus), 40'(model(test_in, 1'h1)));
      chk("oe", 40'(test_out_oe), 40'h00_000F_FFFF);
    end
    sel = 1'h0;
    step(1);
    chk("released", 40'(test_out_oe), 40'h0);
  endtask
  task automatic t_exit();
    en = 1'h0;
    pat = dpct_test_in_t'(31'h0000_0008);
    #1;
    chk("open", {memory_bypass, refresh_allow, odt_active}, 40'h3);
    chk("term", 40'(test_out), 40'(model(test_in, 1'h0)));
    step(1);
    chk("left", {pin_continuity_check_mode, reinit_required}, 40'h1);
    rst = 1'h1;
    step(1);
    rst = 1'h0;
    step(1);
    chk("reinit", reinit_required, 40'h0);
  endtask
  initial begin
    step(16);
    rst = 1'h0;
    step(1);
    chk("reset", {pin_continuity_check_mode, reinit_required, test_out_oe}, 40'h0);
    t_abort();
    t_patterns();
    t_exit();
    wrap_up();
  end
  // Whole run is about 66 cycles; allow several times that
  initial begin
    #(400 * 25);
    failures++;
    wrap_up();
  end
  task automatic wrap_up();
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
endmodule
